// >>> src/rpb_bank.sv
// configuration bank of the buck regulator, reached by command code
// assumes the serial front end delivers one decoded command per strobe
`timescale 1ns/1ps
`default_nettype none
module rpb_bank (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // command port
  input  wire logic        cmdWrite,
  input  wire logic        cmdRead,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [15:0] cmdWdata,
  output logic [15:0]      cmdRdata,
  output logic             cmdAck,
  // fault reporting
  input  wire logic        cmlClear,
  output logic             cmlFault,
  // settings toward the power stage
  output logic [15:0]      slewRate,
  output logic [15:0]      loopScale,
  output logic [1:0]       phaseRole,
  output logic [4:0]       peakLimit,
  output logic [15:0]      avgWarnLevel,
  output logic [3:0]       negLimit,
  output logic [1:0]       ocAction,
  output logic [1:0]       vinOvAction,
  output logic [5:0]       vinOvFilter
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [rpb_pkg::NUM_REGS-1:0][15:0] regs;  // settings by index
    logic [15:0]                        rdata; // read return
    logic                               ack;   // one-cycle answer
    logic                               cml;   // sticky comm fault
  } rpb_state_t;

  rpb_state_t stQ;  // registered state
  rpb_state_t stD;  // next state

  // checker verdict
  logic       known;
  logic       legal;
  logic [4:0] index;
  logic       isByte;

  // ==========================================================================
  // screening of the incoming command
  rpb_check uCheck (
    .cmdCode (cmdCode),
    .cmdData (cmdWdata),
    .known   (known),
    .legal   (legal),
    .index   (index),
    .isByte  (isByte)
  );

  // ==========================================================================
  // reset image of the bank
  function automatic logic [rpb_pkg::NUM_REGS-1:0][15:0] resetImage();
    logic [rpb_pkg::NUM_REGS-1:0][15:0] r;
    r[0]  = rpb_pkg::RST_VOUT_TARGET;
    r[1]  = rpb_pkg::RST_VOUT_CEIL;
    r[2]  = rpb_pkg::RST_MARGIN_HI;
    r[3]  = rpb_pkg::RST_MARGIN_LO;
    r[4]  = rpb_pkg::RST_SLEW;                    // slowest rate
    r[5]  = rpb_pkg::RST_FB_SCALE;                // half
    r[6]  = rpb_pkg::RST_SW_FREQ;
    r[7]  = rpb_pkg::RST_VIN_TURN_ON;
    r[8]  = rpb_pkg::RST_VIN_TURN_OFF;
    r[9]  = rpb_pkg::RST_PHASE_ROLE;              // standalone
    r[10] = {8'h00, rpb_pkg::RST_OV_ACT};
    r[11] = rpb_pkg::RST_UV_WARN;
    r[12] = {8'h00, rpb_pkg::RST_UV_ACT};
    r[13] = rpb_pkg::RST_PEAK_LIM;
    r[14] = {8'h00, rpb_pkg::RST_OC_ACT};         // latch-off
    r[15] = rpb_pkg::RST_AVG_WARN;
    r[16] = rpb_pkg::RST_NEG_LIM;
    r[17] = rpb_pkg::RST_OT_FAULT;
    r[18] = {8'h00, rpb_pkg::RST_OT_ACT};
    r[19] = rpb_pkg::RST_OT_WARN;
    r[20] = rpb_pkg::RST_VIN_OV_LVL;
    r[21] = {8'h00, rpb_pkg::RST_VIN_OV_ACT};     // recovery
    r[22] = rpb_pkg::RST_START_DLY;
    r[23] = rpb_pkg::RST_START_RAMP;
    r[24] = rpb_pkg::RST_START_TMO;
    resetImage = r;
  endfunction : resetImage

  // ==========================================================================
  // next-state logic
  always_comb begin
    stD     = stQ;
    stD.ack = cmdWrite | cmdRead;
    // writes commit only when the value passes the screen
    if (cmdWrite && legal) begin
      stD.regs[index] = cmdWdata;
    end
    // reads of unknown codes return zero
    if (cmdRead) begin
      stD.rdata = known ? stQ.regs[index] : 16'h0000;
    end
    // clear first, so a fault in the same cycle wins
    if (cmlClear) begin
      stD.cml = 1'b0;
    end
    if ((cmdWrite && !legal) || (cmdRead && !known)) begin
      stD.cml = 1'b1;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stQ.regs  <= resetImage();
      stQ.rdata <= 16'h0000;
      stQ.ack   <= 1'b0;
      stQ.cml   <= 1'b0;
    end else begin
      stQ <= stD;
    end
  end

  // ==========================================================================
  // outputs, all straight from flip-flops; the power stage applies limits
  // on every switching cycle from these levels
  assign cmdRdata     = stQ.rdata;
  assign cmdAck       = stQ.ack;
  assign cmlFault     = stQ.cml;
  assign slewRate     = stQ.regs[rpb_pkg::IDX_SLEW];
  assign loopScale    = stQ.regs[rpb_pkg::IDX_FB];
  assign phaseRole    = stQ.regs[rpb_pkg::IDX_ROLE][1:0];
  assign peakLimit    = stQ.regs[rpb_pkg::IDX_PEAK][4:0];
  assign avgWarnLevel = stQ.regs[rpb_pkg::IDX_AVG];
  assign negLimit     = stQ.regs[rpb_pkg::IDX_NEG][3:0];
  assign ocAction     = stQ.regs[rpb_pkg::IDX_OC][rpb_pkg::ACT_MSB:rpb_pkg::ACT_LSB];
  assign vinOvAction  = stQ.regs[rpb_pkg::IDX_VINA][rpb_pkg::ACT_MSB:rpb_pkg::ACT_LSB];
  assign vinOvFilter  = stQ.regs[rpb_pkg::IDX_VINA][5:0];

  // ==========================================================================
  // checks
  AST_SLEW_LEGAL: assert property (@(posedge clk) disable iff (!arst_n)
    (slewRate == rpb_pkg::SLEW_OPT0) || (slewRate == rpb_pkg::SLEW_OPT1)
    || (slewRate == rpb_pkg::SLEW_OPT2) || (slewRate == rpb_pkg::SLEW_OPT3))
    else $error("slew setting holds an illegal code");

  AST_SCALE_LEGAL: assert property (@(posedge clk) disable iff (!arst_n)
    (loopScale == rpb_pkg::SCALE_QTR) || (loopScale == rpb_pkg::SCALE_HALF)
    || (loopScale == rpb_pkg::SCALE_ONE))
    else $error("loop scale holds an illegal code");

  AST_ROLE_HIGH_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
    stQ.regs[rpb_pkg::IDX_ROLE] <= rpb_pkg::ROLE_MAX)
    else $error("phase role out of range");

  AST_VINOV_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
    (cmdWrite && cmdCode == rpb_pkg::CMD_VIN_OV_ACT && cmdWdata[15:8] == 8'h00)
    |=> (vinOvAction == $past(cmdWdata[7:6])) && (vinOvFilter == $past(cmdWdata[5:0])))
    else $error("input overvoltage action not stored");

  AST_PEAK_RANGE: assert property (@(posedge clk) disable iff (!arst_n)
    (peakLimit >= rpb_pkg::PEAK_MIN[4:0]) && (peakLimit <= rpb_pkg::PEAK_MAX[4:0]))
    else $error("peak limit out of range");

  AST_AVG_RANGE: assert property (@(posedge clk) disable iff (!arst_n)
    (avgWarnLevel[15:11] == rpb_pkg::AVG_EXP) && (avgWarnLevel[10:0] >= rpb_pkg::AVG_MANT_MIN)
    && (avgWarnLevel[10:0] <= rpb_pkg::AVG_MANT_MAX))
    else $error("average warn level out of range");

  AST_NEG_RANGE: assert property (@(posedge clk) disable iff (!arst_n)
    (negLimit >= rpb_pkg::NEG_MIN[3:0]) && (negLimit <= rpb_pkg::NEG_MAX[3:0]))
    else $error("negative limit out of range");

  AST_OC_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
    (cmdWrite && cmdCode == rpb_pkg::CMD_OC_ACT && cmdWdata[15:8] == 8'h00)
    |=> ocAction == $past(cmdWdata[7:6]))
    else $error("overcurrent action not stored");

  AST_BAD_KEEPS: assert property (@(posedge clk) disable iff (!arst_n)
    (cmdWrite && !legal && !cmlClear) |=> cmlFault && $stable(stQ.regs))
    else $error("rejected write changed the bank or missed the fault");

  AST_BYTE_UPPER: assert property (@(posedge clk) disable iff (!arst_n)
    (cmdWrite && isByte && (cmdWdata[15:8] != 8'h00)) |=> cmlFault && $stable(stQ.regs))
    else $error("byte write with upper bits set was not refused");

  AST_ACK_ONE: assert property (@(posedge clk) disable iff (!arst_n)
    (cmdWrite || cmdRead) |=> cmdAck)
    else $error("command not answered");

endmodule : rpb_bank
`default_nettype wire

// >>> src/rpb_check.sv
// range and option checker for one incoming command write
// assumes code and data are stable in the cycle of the write strobe
`timescale 1ns/1ps
`default_nettype none
module rpb_check (
  // command under test
  input  wire logic [7:0]  cmdCode,
  input  wire logic [15:0] cmdData,
  // verdict
  output logic             known,
  output logic             legal,
  output logic [4:0]       index,
  output logic             isByte
);

  // ==========================================================================
  // window check on an unsigned word
  function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction : inRange

  // ==========================================================================
  // decode and screen; unscreened settings accept any value
  always_comb begin
    known  = 1'b1;
    legal  = 1'b1;
    isByte = 1'b0;
    index  = 5'h00;
    case (cmdCode)
      rpb_pkg::CMD_VOUT_TARGET:  index = 5'd0;
      rpb_pkg::CMD_VOUT_CEIL:    index = 5'd1;
      rpb_pkg::CMD_MARGIN_HI:    index = 5'd2;
      rpb_pkg::CMD_MARGIN_LO:    index = 5'd3;
      rpb_pkg::CMD_SLEW: begin
        index = 5'd4;
        legal = (cmdData == rpb_pkg::SLEW_OPT0) || (cmdData == rpb_pkg::SLEW_OPT1)
             || (cmdData == rpb_pkg::SLEW_OPT2) || (cmdData == rpb_pkg::SLEW_OPT3);
      end
      rpb_pkg::CMD_FB_SCALE: begin
        index = 5'd5;
        legal = (cmdData == rpb_pkg::SCALE_QTR) || (cmdData == rpb_pkg::SCALE_HALF)
             || (cmdData == rpb_pkg::SCALE_ONE);
      end
      rpb_pkg::CMD_SW_FREQ:      index = 5'd6;
      rpb_pkg::CMD_VIN_TURN_ON:  index = 5'd7;
      rpb_pkg::CMD_VIN_TURN_OFF: index = 5'd8;
      rpb_pkg::CMD_PHASE_ROLE: begin
        index = 5'd9;
        legal = (cmdData <= rpb_pkg::ROLE_MAX);
      end
      rpb_pkg::CMD_OV_ACT:     begin index = 5'd10; isByte = 1'b1; end
      rpb_pkg::CMD_UV_WARN:    index = 5'd11;
      rpb_pkg::CMD_UV_ACT:     begin index = 5'd12; isByte = 1'b1; end
      rpb_pkg::CMD_PEAK_LIM: begin
        index = 5'd13;
        legal = inRange(cmdData, rpb_pkg::PEAK_MIN, rpb_pkg::PEAK_MAX);
      end
      rpb_pkg::CMD_OC_ACT:     begin index = 5'd14; isByte = 1'b1; end
      rpb_pkg::CMD_AVG_WARN: begin
        index = 5'd15;
        legal = (cmdData[15:11] == rpb_pkg::AVG_EXP)
             && ({5'h00, cmdData[10:0]} >= {5'h00, rpb_pkg::AVG_MANT_MIN})
             && ({5'h00, cmdData[10:0]} <= {5'h00, rpb_pkg::AVG_MANT_MAX});
      end
      rpb_pkg::CMD_NEG_LIM: begin
        index = 5'd16;
        legal = inRange(cmdData, rpb_pkg::NEG_MIN, rpb_pkg::NEG_MAX);
      end
      rpb_pkg::CMD_OT_FAULT:   index = 5'd17;
      rpb_pkg::CMD_OT_ACT:     begin index = 5'd18; isByte = 1'b1; end
      rpb_pkg::CMD_OT_WARN:    index = 5'd19;
      rpb_pkg::CMD_VIN_OV_LVL: index = 5'd20;
      rpb_pkg::CMD_VIN_OV_ACT: begin index = 5'd21; isByte = 1'b1; end
      rpb_pkg::CMD_START_DLY:  index = 5'd22;
      rpb_pkg::CMD_START_RAMP: index = 5'd23;
      rpb_pkg::CMD_START_TMO:  index = 5'd24;
      default: begin
        known = 1'b0;
        legal = 1'b0;
      end
    endcase
    // byte commands: upper byte must be clear
    if (isByte && (cmdData[15:8] != 8'h00)) begin
      legal = 1'b0;
    end
  end

endmodule : rpb_check
`default_nettype wire

// >>> src/rpb_pkg.sv
// package of command codes, reset values and option codes for the config bank
// assumes a command-level port: code, write strobe, data word, read data
package rpb_pkg;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_VOUT_TARGET  = 8'h21;
  localparam logic [7:0] CMD_VOUT_CEIL    = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HI    = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LO    = 8'h26;
  localparam logic [7:0] CMD_SLEW         = 8'h27;
  localparam logic [7:0] CMD_FB_SCALE     = 8'h29;
  localparam logic [7:0] CMD_SW_FREQ      = 8'h33;
  localparam logic [7:0] CMD_VIN_TURN_ON  = 8'h35;
  localparam logic [7:0] CMD_VIN_TURN_OFF = 8'h36;
  localparam logic [7:0] CMD_PHASE_ROLE   = 8'h37;
  localparam logic [7:0] CMD_OV_ACT       = 8'h41;
  localparam logic [7:0] CMD_UV_WARN      = 8'h43;
  localparam logic [7:0] CMD_UV_ACT       = 8'h45;
  localparam logic [7:0] CMD_PEAK_LIM     = 8'h46;
  localparam logic [7:0] CMD_OC_ACT       = 8'h47;
  localparam logic [7:0] CMD_AVG_WARN     = 8'h4a;
  localparam logic [7:0] CMD_NEG_LIM      = 8'h4b;
  localparam logic [7:0] CMD_OT_FAULT     = 8'h4f;
  localparam logic [7:0] CMD_OT_ACT       = 8'h50;
  localparam logic [7:0] CMD_OT_WARN      = 8'h51;
  localparam logic [7:0] CMD_VIN_OV_LVL   = 8'h55;
  localparam logic [7:0] CMD_VIN_OV_ACT   = 8'h56;
  localparam logic [7:0] CMD_START_DLY    = 8'h60;
  localparam logic [7:0] CMD_START_RAMP   = 8'h61;
  localparam logic [7:0] CMD_START_TMO    = 8'h62;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_VOUT_TARGET  = 16'h0000;
  localparam logic [15:0] RST_VOUT_CEIL    = 16'h0b00;
  localparam logic [15:0] RST_MARGIN_HI    = 16'h06cd;
  localparam logic [15:0] RST_MARGIN_LO    = 16'h0667;
  localparam logic [15:0] RST_SLEW         = 16'hd00d;
  localparam logic [15:0] RST_FB_SCALE     = 16'hf002;
  localparam logic [15:0] RST_SW_FREQ      = 16'h092c;
  localparam logic [15:0] RST_VIN_TURN_ON  = 16'hf80c;
  localparam logic [15:0] RST_VIN_TURN_OFF = 16'hf80b;
  localparam logic [15:0] RST_PHASE_ROLE   = 16'h0000;
  localparam logic [7:0]  RST_OV_ACT       = 8'h40;
  localparam logic [15:0] RST_UV_WARN      = 16'h0067;
  localparam logic [7:0]  RST_UV_ACT       = 8'h40;
  localparam logic [15:0] RST_PEAK_LIM     = 16'h0019;
  localparam logic [7:0]  RST_OC_ACT       = 8'h80;
  localparam logic [15:0] RST_AVG_WARN     = 16'he0d0;
  localparam logic [15:0] RST_NEG_LIM      = 16'h0008;
  localparam logic [15:0] RST_OT_FAULT     = 16'h008c;
  localparam logic [7:0]  RST_OT_ACT       = 8'hc0;
  localparam logic [15:0] RST_OT_WARN      = 16'h0073;
  localparam logic [15:0] RST_VIN_OV_LVL   = 16'h080a;
  localparam logic [7:0]  RST_VIN_OV_ACT   = 8'hc0;
  localparam logic [15:0] RST_START_DLY    = 16'h0001;
  localparam logic [15:0] RST_START_RAMP   = 16'h0005;
  localparam logic [15:0] RST_START_TMO    = 16'h0806;

  // ==========================================================================
  // accepted option codes (linear words for slew and scale)
  localparam logic [15:0] SLEW_OPT0  = 16'hd00d;  // slowest rate
  // all four rates share exponent -6, so mantissa / 64 gives mV per us
  localparam logic [15:0] SLEW_OPT1  = 16'hd07d;  // 125 / 64
  localparam logic [15:0] SLEW_OPT2  = 16'hd0bb;  // 187 / 64
  localparam logic [15:0] SLEW_OPT3  = 16'hd258;  // 600 / 64, fastest rate
  localparam logic [15:0] SCALE_QTR  = 16'hf001;
  localparam logic [15:0] SCALE_HALF = 16'hf002;
  localparam logic [15:0] SCALE_ONE  = 16'hf004;
  localparam logic [15:0] ROLE_MAX   = 16'h0003;  // four role codes 0..3

  // ==========================================================================
  // range limits, linear-integer amps
  localparam logic [15:0] PEAK_MIN   = 16'h0001;
  localparam logic [15:0] PEAK_MAX   = 16'h001f;
  localparam logic [15:0] NEG_MIN    = 16'h0005;
  localparam logic [15:0] NEG_MAX    = 16'h000c;
  // average warn: exponent -4 (62.5 mA), mantissa 16..1024
  localparam logic [4:0]  AVG_EXP    = 5'h1c;
  localparam logic [10:0] AVG_MANT_MIN = 11'h010;
  localparam logic [10:0] AVG_MANT_MAX = 11'h400;
  // action byte: bits 7:6 action, 5:0 filter
  localparam int          ACT_MSB    = 7;
  localparam int          ACT_LSB    = 6;

  // ==========================================================================
  // register indices
  localparam int NUM_REGS = 25;
  localparam int IDX_SLEW = 4;
  localparam int IDX_FB   = 5;
  localparam int IDX_ROLE = 9;
  localparam int IDX_OC   = 14;
  localparam int IDX_PEAK = 13;
  localparam int IDX_AVG  = 15;
  localparam int IDX_NEG  = 16;
  localparam int IDX_VINA = 21;

  typedef enum logic [1:0] {ROLE_ALONE, ROLE_MASTER, ROLE_SLAVE0, ROLE_SLAVE180} rpb_role_t;

endpackage : rpb_pkg

// >>> verif/rpb_host_model.sv
// command-level host model that issues reads and writes to the config bank
// assumes the bank answers every strobe with an ack one edge later
`timescale 1ns/1ps
`default_nettype none
module rpb_host_model (
  // clock
  input  wire logic        clk,
  // answers from the bank
  input  wire logic        cmdAck,
  input  wire logic [15:0] cmdRdata,
  // requests toward the bank
  output logic             cmdWrite,
  output logic             cmdRead,
  output logic [7:0]       cmdCode,
  output logic [15:0]      cmdWdata,
  output logic             cmlClear
);
  // idle values at time zero
  initial begin
    cmdWrite = 1'b0;
    cmdRead  = 1'b0;
    cmdCode  = 8'h00;
    cmdWdata = 16'h0000;
    cmlClear = 1'b0;
  end
  // ==========================================================================
  // one strobe, answer taken at the edge after it
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic ack, output logic [15:0] rd);
    @(posedge clk);
    #1;
    cmdWrite = wr;
    cmdRead  = ~wr;
    cmdCode  = code;
    cmdWdata = data;
    @(posedge clk);
    #1;
    ack      = cmdAck;
    rd       = cmdRdata;
    cmdWrite = 1'b0;
    cmdRead  = 1'b0;
    // released lines flip so a stale value never looks valid
    cmdCode  = ~code;
    cmdWdata = ~data;
  endtask : xfer
  // one-cycle clear pulse for the fault flag
  task automatic clear();
    @(posedge clk);
    #1;
    cmlClear = 1'b1;
    @(posedge clk);
    #1;
    cmlClear = 1'b0;
  endtask : clear
endmodule : rpb_host_model
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the regulator config bank
// assumes the host model drives the command port on the bench's behalf
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk;           // 100 MHz
  logic        arst_n;        // async reset, active low
  logic        cmdWrite, cmdRead, cmlClear, cmdAck, cmlFault;
  logic [7:0]  cmdCode;
  logic [15:0] cmdWdata, cmdRdata, slewRate, loopScale, avgWarnLevel;
  logic [1:0]  phaseRole, ocAction, vinOvAction;
  logic [4:0]  peakLimit;
  logic [3:0]  negLimit;
  logic [5:0]  vinOvFilter;
  int          err_total, num_checks, cycles;
  // ==========================================================================
  // instances
  rpb_bank i_dut (.clk(clk), .arst_n(arst_n), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdCode(cmdCode), .cmdWdata(cmdWdata), .cmdRdata(cmdRdata), .cmdAck(cmdAck),
    .cmlClear(cmlClear), .cmlFault(cmlFault), .slewRate(slewRate), .loopScale(loopScale),
    .phaseRole(phaseRole), .peakLimit(peakLimit), .avgWarnLevel(avgWarnLevel),
    .negLimit(negLimit), .ocAction(ocAction), .vinOvAction(vinOvAction),
    .vinOvFilter(vinOvFilter));
  rpb_host_model i_host (.clk(clk), .cmdAck(cmdAck), .cmdRdata(cmdRdata),
    .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode), .cmdWdata(cmdWdata),
    .cmlClear(cmlClear));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the few hundred operations run here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [7:0] code, output logic [15:0] v);
    logic ack;
    i_host.xfer(1'b0, code, 16'h0000, ack, v);
    chk("read ack", {15'h0, ack}, 16'h0001);
  endtask : rd
  // write, judge flag and readback: refused writes leave the old value
  task automatic put(input logic [7:0] code, input logic [15:0] v, input logic ok);
    logic [15:0] old;
    logic [15:0] back;
    logic        ack;
    rd(code, old);
    i_host.xfer(1'b1, code, v, ack, back);
    chk("write ack", {15'h0, ack}, 16'h0001);
    chk("fault flag", {15'h0, cmlFault}, {15'h0, ~ok});
    rd(code, back);
    chk("readback", back, ok ? v : old);
    i_host.clear();
    chk("fault cleared", {15'h0, cmlFault}, 16'h0000);
  endtask : put
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // scenarios
  task automatic test_reset();
    logic [7:0]  codes [25] = '{8'h21, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29, 8'h33, 8'h35,
      8'h36, 8'h37, 8'h41, 8'h43, 8'h45, 8'h46, 8'h47, 8'h4a, 8'h4b, 8'h4f, 8'h50, 8'h51,
      8'h55, 8'h56, 8'h60, 8'h61, 8'h62};
    logic [15:0] rst [25] = '{16'h0000, 16'h0b00, 16'h06cd, 16'h0667, 16'hd00d, 16'hf002,
      16'h092c, 16'hf80c, 16'hf80b, 16'h0000, 16'h0040, 16'h0067, 16'h0040, 16'h0019,
      16'h0080, 16'he0d0, 16'h0008, 16'h008c, 16'h00c0, 16'h0073, 16'h080a, 16'h00c0,
      16'h0001, 16'h0005, 16'h0806};
    logic [15:0] v;
    chk("slew out", slewRate, 16'hd00d);
    chk("scale out", loopScale, 16'hf002);
    chk("role out", {14'h0, phaseRole}, 16'h0000);
    chk("vin ov action", {14'h0, vinOvAction}, 16'h0003);
    chk("peak out", {11'h0, peakLimit}, 16'h0019);
    chk("avg out", avgWarnLevel, 16'he0d0);
    chk("neg out", {12'h0, negLimit}, 16'h0008);
    chk("oc action", {14'h0, ocAction}, 16'h0002);
    chk("fault at reset", {15'h0, cmlFault}, 16'h0000);
    for (int i = 0; i < 25; i++) begin
      rd(codes[i], v);
      chk("reset value", v, rst[i]);
    end
    $display("test reset done");
  endtask : test_reset
  task automatic test_slew_scale();
    logic [15:0] slew [4] = '{16'hd258, 16'hd0bb, 16'hd07d, 16'hd00d};
    logic [15:0] scl [3] = '{16'hf001, 16'hf004, 16'hf002};
    foreach (slew[i]) begin
      put(8'h27, slew[i], 1'b1);
      chk("slew out", slewRate, slew[i]);
    end
    put(8'h27, 16'hd00e, 1'b0);
    chk("slew kept", slewRate, 16'hd00d);
    foreach (scl[i]) begin
      put(8'h29, scl[i], 1'b1);
      chk("scale out", loopScale, scl[i]);
    end
    put(8'h29, 16'hf003, 1'b0);
    put(8'h29, 16'hf008, 1'b0);
    chk("scale kept", loopScale, 16'hf002);
    $display("test slew and scale done");
  endtask : test_slew_scale
  task automatic test_role();
    for (int r = 0; r < 4; r++) begin
      put(8'h37, r[15:0], 1'b1);
      chk("role out", {14'h0, phaseRole}, r[15:0]);
    end
    put(8'h37, 16'h0004, 1'b0);
    chk("role kept", {14'h0, phaseRole}, 16'h0003);
    $display("test role done");
  endtask : test_role
  task automatic test_limits();
    put(8'h46, 16'h0001, 1'b1);
    put(8'h46, 16'h0000, 1'b0);
    put(8'h46, 16'h001f, 1'b1);
    put(8'h46, 16'h0020, 1'b0);
    chk("peak out", {11'h0, peakLimit}, 16'h001f);
    put(8'h4b, 16'h0005, 1'b1);
    put(8'h4b, 16'h0004, 1'b0);
    put(8'h4b, 16'h000c, 1'b1);
    put(8'h4b, 16'h000d, 1'b0);
    chk("neg out", {12'h0, negLimit}, 16'h000c);
    put(8'h4a, 16'he010, 1'b1);
    put(8'h4a, 16'he00f, 1'b0);
    put(8'h4a, 16'he400, 1'b1);
    put(8'h4a, 16'he401, 1'b0);
    put(8'h4a, 16'he810, 1'b0);
    chk("avg out", avgWarnLevel, 16'he400);
    put(8'h33, 16'h1234, 1'b1);
    $display("test limits done");
  endtask : test_limits
  task automatic test_actions();
    logic        ack;
    logic [15:0] v;
    for (int a = 0; a < 4; a++) begin
      put(8'h47, {8'h00, a[1:0], 6'h00}, 1'b1);
      chk("oc action", {14'h0, ocAction}, a[15:0]);
    end
    put(8'h56, 16'h0005, 1'b1);
    chk("vin ov action", {14'h0, vinOvAction}, 16'h0000);
    put(8'h56, 16'h00c7, 1'b1);
    chk("vin ov filter", {10'h0, vinOvFilter}, 16'h0007);
    put(8'h56, 16'h0140, 1'b0);
    chk("vin ov kept", {14'h0, vinOvAction}, 16'h0003);
    i_host.xfer(1'b1, 8'h22, 16'h0001, ack, v);
    chk("unknown write flag", {15'h0, cmlFault}, 16'h0001);
    i_host.clear();
    rd(8'h22, v);
    chk("unknown read data", v, 16'h0000);
    chk("unknown read flag", {15'h0, cmlFault}, 16'h0001);
    i_host.clear();
    $display("test actions done");
  endtask : test_actions
  // ==========================================================================
  // main sequence
  initial begin
    arst_n     = 1'b0;
    err_total  = 0;
    num_checks = 0;
    cycles     = 0;
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1'b1;
    test_reset();
    test_slew_scale();
    test_role();
    test_limits();
    test_actions();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
